// ===== logic/qecnt_top.sv
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module qecnt_top
  import qecnt_pkg::*;
#(
  parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic ENC_C,
  input wire logic LATCH_IN,
  input wire logic GATE_IN,
  input wire logic ALARM_IN_N,
  input wire logic [2:0] OPEN_DETECT,
  output logic ALARM_LED,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  logic [8:0] pins_s;
  logic a_s, b_s, c_s, latch_s, gate_s, alarm_n_s;
  logic [2:0] open_s;

  // Pin synchronisers, alarm idles high as with its pull-up
  qecnt_sync #(.W(9), .RST(9'h020)) u_sync (
    .clk(CLK),
    .reset(RESET),
    .d({OPEN_DETECT, ALARM_IN_N, GATE_IN, LATCH_IN, ENC_C, ENC_B, ENC_A}),
    .q(pins_s)
  );
  assign {open_s, alarm_n_s, gate_s, latch_s, c_s, b_s, a_s} = pins_s;

  qecnt_ctrl_t ctrl_reg, ctrl_next;
  logic [31:0] preset_reg, preset_next;
  logic [3:0] state_reg, state_next;
  logic [31:0] count_reg, count_next;
  logic [31:0] capture_reg, capture_next;
  logic cap_valid_reg, cap_valid_next;
  logic [1:0] ab_prev_reg, ab_prev_next;
  logic c_prev_reg, c_prev_next;
  logic latch_prev_reg, latch_prev_next;
  logic [31:0] ts_reg, ts_next;
  logic [31:0] edge_ts_reg, edge_ts_next;
  logic [31:0] since_reg, since_next;
  logic [31:0] sample_cnt_reg, sample_cnt_next;
  logic toggle_reg, toggle_next;
  logic [31:0] pd_count_reg, pd_count_next;
  logic [31:0] pd_capture_reg, pd_capture_next;
  qecnt_status_t pd_status_reg, pd_status_next;
  logic led_reg, led_next;
  logic aw_hold_reg, aw_hold_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic w_hold_reg, w_hold_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // Merge written bytes into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] width_mask, cap_mask;
  logic step_up, step_dn, any_edge, a_rise, c_rise, latch_rise;
  logic [2:0] open_fault;
  logic broken, alarm_err, wr_fire, sample_tick;
  logic [31:0] cmd_bits;
  qecnt_status_t status_now;

  // Decoder, counter, capture and mode qualifiers
  always_comb begin
    width_mask = (ctrl_reg.enhanced && ctrl_reg.wide) ? MASK32 : MASK16;
    cap_mask = ctrl_reg.enhanced ? MASK32 : MASK16;
    a_rise = a_s & ~ab_prev_reg[1];
    c_rise = c_s & ~c_prev_reg;
    latch_rise = latch_s & ~latch_prev_reg;
    any_edge = ({a_s, b_s} != ab_prev_reg);
    step_up = 1'b0;
    step_dn = 1'b0;
    if (ctrl_reg.pulse_mode) begin
      step_up = a_rise & ~b_s;
      step_dn = a_rise & b_s;
    end else begin
      // AB sequence 00,10,11,01 counts up
      case ({ab_prev_reg, a_s, b_s})
        4'b0010, 4'b1011, 4'b1101, 4'b0100: step_up = 1'b1;
        4'b0001, 4'b0111, 4'b1110, 4'b1000: step_dn = 1'b1;
        default: begin
          step_up = 1'b0;
          step_dn = 1'b0;
        end
      endcase
    end
    open_fault = ctrl_reg.enhanced ? (open_s & ctrl_reg.open_en) : 3'b000;
    broken = |open_fault;
    alarm_err = ~alarm_n_s;
    sample_tick = (sample_cnt_reg == 32'(SAMPLE_PERIOD - 1));
    wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    cmd_bits = (wr_fire && aw_addr_reg == OFS_CMD) ? (w_data_reg & {{8{w_strb_reg[3]}},
      {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}}) : 32'h0000_0000;
    status_now = '0;
    status_now.capture_valid = cap_valid_reg;
    status_now.enhanced = ctrl_reg.enhanced;
    status_now.alarm_error = alarm_err;
    status_now.broken_wire = broken;
    status_now.input_data_invalid = broken;
    status_now.sync_fault_flag = broken;
    status_now.new_sample_toggle = ~toggle_reg;
    status_now.working_counter_flag = (state_reg != STATE_OP);
    status_now.gate_active = ctrl_reg.gate_en & gate_s;
    status_now.open_fault = open_fault;
    status_now.state_code = state_reg;
  end

  // Counting datapath next state
  always_comb begin
    ab_prev_next = {a_s, b_s};
    c_prev_next = c_s;
    latch_prev_next = latch_s;
    count_next = count_reg & width_mask;
    if (cmd_bits[CMD_LOAD_COUNT]) begin
      count_next = preset_reg & width_mask;
    end else if (ctrl_reg.count_en && !(ctrl_reg.gate_en && gate_s)) begin
      if (step_up) begin
        count_next = (count_reg + 32'h0000_0001) & width_mask;
      end else if (step_dn) begin
        count_next = (count_reg - 32'h0000_0001) & width_mask;
      end
    end
    capture_next = capture_reg;
    cap_valid_next = cap_valid_reg;
    if (cmd_bits[CMD_CLEAR_VALID]) begin
      cap_valid_next = 1'b0;
    end
    if (cmd_bits[CMD_LOAD_CAPTURE]) begin
      capture_next = preset_reg & cap_mask;
    end
    // Capture event wins over a clear in the same cycle
    if ((ctrl_reg.zero_cap_en && c_rise) || (ctrl_reg.latch_cap_en && latch_rise)) begin
      capture_next = count_reg & cap_mask;
      cap_valid_next = 1'b1;
    end
    ts_next = ts_reg + 32'h0000_0001;
    edge_ts_next = edge_ts_reg;
    since_next = (since_reg == MASK32) ? since_reg : since_reg + 32'h0000_0001;
    if (ctrl_reg.enhanced && any_edge) begin
      edge_ts_next = ts_reg;
      since_next = 32'h0000_0000;
    end
    sample_cnt_next = sample_tick ? 32'h0000_0000 : sample_cnt_reg + 32'h0000_0001;
    toggle_next = toggle_reg;
    pd_count_next = pd_count_reg;
    pd_capture_next = pd_capture_reg;
    pd_status_next = pd_status_reg;
    if (sample_tick) begin
      toggle_next = ~toggle_reg;
      pd_count_next = count_reg & width_mask;
      pd_capture_next = capture_reg;
      pd_status_next = status_now;
    end
    led_next = alarm_err;
  end

  // Register bus next state
  always_comb begin
    ctrl_next = ctrl_reg;
    preset_next = preset_reg;
    state_next = state_reg;
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_hold_next = 1'b1;
      aw_addr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_hold_next = 1'b1;
      w_data_next = S_AXI_WDATA;
      w_strb_next = S_AXI_WSTRB;
    end
    if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (aw_addr_reg)
        OFS_CTRL: begin
          ctrl_next = merge(ctrl_reg, w_data_reg, w_strb_reg);
          ctrl_next.rsvd = '0; // Reserved bits are cleared so they read back as zero
        end
        OFS_PRESET: preset_next = merge(preset_reg, w_data_reg, w_strb_reg);
        OFS_STATE: if (w_strb_reg[0]) begin
          state_next = w_data_reg[3:0];
        end
        OFS_CMD, OFS_COUNT, OFS_CAPTURE, OFS_STATUS, OFS_EDGE_TS, OFS_MICRO: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (S_AXI_ARADDR)
        OFS_CTRL: rdata_next = ctrl_reg;
        OFS_PRESET: rdata_next = preset_reg;
        OFS_CMD: rdata_next = 32'h0000_0000;
        OFS_COUNT: rdata_next = pd_count_reg;
        OFS_CAPTURE: rdata_next = pd_capture_reg;
        OFS_STATUS: rdata_next = pd_status_reg;
        OFS_EDGE_TS: rdata_next = ctrl_reg.enhanced ? edge_ts_reg : 32'h0000_0000;
        OFS_MICRO: rdata_next = ctrl_reg.enhanced ? since_reg : 32'h0000_0000;
        OFS_STATE: rdata_next = {28'h000_0000, state_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_reg <= CTRL_RESET;
      preset_reg <= PRESET_RESET;
      state_reg <= STATE_INIT;
      count_reg <= 32'h0000_0000;
      capture_reg <= 32'h0000_0000;
      cap_valid_reg <= 1'b0;
      ab_prev_reg <= 2'b00;
      c_prev_reg <= 1'b0;
      latch_prev_reg <= 1'b0;
      ts_reg <= 32'h0000_0000;
      edge_ts_reg <= 32'h0000_0000;
      since_reg <= 32'h0000_0000;
      sample_cnt_reg <= 32'h0000_0000;
      toggle_reg <= 1'b0;
      pd_count_reg <= 32'h0000_0000;
      pd_capture_reg <= 32'h0000_0000;
      pd_status_reg <= '0;
      led_reg <= 1'b0;
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      ctrl_reg <= ctrl_next;
      preset_reg <= preset_next;
      state_reg <= state_next;
      count_reg <= count_next;
      capture_reg <= capture_next;
      cap_valid_reg <= cap_valid_next;
      ab_prev_reg <= ab_prev_next;
      c_prev_reg <= c_prev_next;
      latch_prev_reg <= latch_prev_next;
      ts_reg <= ts_next;
      edge_ts_reg <= edge_ts_next;
      since_reg <= since_next;
      sample_cnt_reg <= sample_cnt_next;
      toggle_reg <= toggle_next;
      pd_count_reg <= pd_count_next;
      pd_capture_reg <= pd_capture_next;
      pd_status_reg <= pd_status_next;
      led_reg <= led_next;
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Ready flags registered from next hold state and next read-valid state
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_ARREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_hold_next;
      S_AXI_WREADY <= !w_hold_next;
      S_AXI_ARREADY <= !rvalid_next;
    end
  end

  assign ALARM_LED = led_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
endmodule

// ===== logic/qecnt_pkg.sv
package qecnt_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 100;
  localparam int SAMPLE_US = 100;
  localparam int SAMPLE_CYCLES = SAMPLE_US * CLK_MHZ;
  localparam int MAX_TRACK_KHZ = 5000;
  localparam int EDGES_PER_PERIOD = 4;
  localparam int MIN_EDGE_CYCLES = (CLK_MHZ * 1000) / (MAX_TRACK_KHZ * EDGES_PER_PERIOD);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_CAPTURE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_EDGE_TS = 8'h18;
  localparam logic [7:0] OFS_MICRO = 8'h1C;
  localparam logic [7:0] OFS_STATE = 8'h24;

  // Command bit positions
  localparam int CMD_LOAD_COUNT = 0;
  localparam int CMD_LOAD_CAPTURE = 1;
  localparam int CMD_CLEAR_VALID = 2;

  // Reset values and codes
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PRESET_RESET = 32'h0000_0000;
  localparam logic [3:0] STATE_INIT = 4'h1;
  localparam logic [3:0] STATE_OP = 4'h8;
  localparam logic [31:0] MASK16 = 32'h0000_FFFF;
  localparam logic [31:0] MASK32 = 32'hFFFF_FFFF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Control register layout
  typedef struct packed {
    logic [21:0] rsvd;
    logic [2:0] open_en;
    logic gate_en;
    logic latch_cap_en;
    logic zero_cap_en;
    logic count_en;
    logic pulse_mode;
    logic wide;
    logic enhanced;
  } qecnt_ctrl_t;

  // Status register layout
  typedef struct packed {
    logic [15:0] rsvd;
    logic [3:0] state_code;
    logic [2:0] open_fault;
    logic gate_active;
    logic working_counter_flag;
    logic new_sample_toggle;
    logic sync_fault_flag;
    logic input_data_invalid;
    logic broken_wire;
    logic alarm_error;
    logic enhanced;
    logic capture_valid;
  } qecnt_status_t;
endpackage

// ===== logic/qecnt_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for asynchronous pins
module qecnt_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= RST;
      q <= RST;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ===== test/qecnt_asserts.sv
`timescale 1ns/100ps
module qecnt_asserts
  import qecnt_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic ALARM_IN_N,
  input wire logic ALARM_LED,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // Alarm pin to indicator, three cycles through
  AST_ALARM_ON: assert property ((!ALARM_IN_N) [*4] |-> ALARM_LED)
    else $error("alarm indicator stayed off");
  AST_ALARM_OFF: assert property (ALARM_IN_N [*4] |-> !ALARM_LED)
    else $error("alarm indicator lit while idle");
  // Write and read answers
  AST_B_LATENCY: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_AWREADY ##1 S_AXI_BVALID)
    else $error("write answer late");
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  AST_B_BLOCK: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  AST_R_LATENCY: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer changed");
  AST_R_DONE: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");
  AST_R_SLVERR: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h20
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");
  // Main scenarios reached
  COV_WRITE: cover property (S_AXI_BVALID && S_AXI_BREADY);
  COV_READ: cover property (S_AXI_RVALID && S_AXI_RREADY);
  COV_ALARM: cover property ($rose(ALARM_LED));
endmodule

bind qecnt_top qecnt_asserts qecnt_asserts_i (
  .CLK(CLK),
  .RESET(RESET),
  .ALARM_IN_N(ALARM_IN_N),
  .ALARM_LED(ALARM_LED),
  .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY)
);

// ===== test/qecnt_enc_model.sv
`timescale 1ns/100ps
module qecnt_enc_model (
  input wire logic clk,
  output logic enc_a,
  output logic enc_b,
  output logic enc_c
);
  logic [1:0] ph = 2'd0;
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_c = 1'b0;
  end
  // Gray steps, A leading B when up, edge every five cycles
  task automatic quad(input int n, input bit up);
    for (int i = 0; i < n; i++) begin
      repeat (5) @(posedge clk);
      ph = up ? ph + 2'd1 : ph - 2'd1;
      enc_a <= ph[0] ^ ph[1];
      enc_b <= ph[1];
    end
  endtask
  // Pulses on A, direction level on B
  task automatic pulse(input int n, input bit down);
    @(posedge clk);
    enc_b <= down;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk);
      enc_a <= 1'b1;
      repeat (4) @(posedge clk);
      enc_a <= 1'b0;
    end
    repeat (4) @(posedge clk);
    enc_b <= 1'b0;
  endtask
  // Zero mark on track C
  task automatic zero();
    @(posedge clk);
    enc_c <= 1'b1;
    repeat (5) @(posedge clk);
    enc_c <= 1'b0;
  endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import qecnt_pkg::*;
;
  localparam int SP = 20;
  logic clk, reset, alarm_n, gate, latch, awvalid, wvalid, bready, arvalid, rready;
  logic [2:0] open_det;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd, ex;
  logic [1:0] rsp;
  wire logic enc_a, enc_b, enc_c, led, awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int mismatches, cmp_count, cyc, n, m, t;
  qecnt_enc_model qecnt_enc_model_i (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_c(enc_c));
  qecnt_top #(.SAMPLE_PERIOD(SP)) qecnt_top_i (.CLK(clk), .RESET(reset), .ENC_A(enc_a), .ENC_B(enc_b),
    .ENC_C(enc_c), .LATCH_IN(latch), .GATE_IN(gate), .ALARM_IN_N(alarm_n), .OPEN_DETECT(open_det),
    .ALARM_LED(led), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'b000), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'b000), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  // Clock and cycle count
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait ran out
  task automatic tmo(input int k);
    if (k >= 50) begin
      mismatches++;
      close_out();
    end
  endtask
  // Write: address and data together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(awready && wready) && !(awready && !wvalid) && !(wready && !awvalid) && k < 50);
    do begin
      @(posedge clk);
      k++;
    end while (!bvalid && k < 50);
    bready <= 1'b0;
    rsp = bresp;
    tmo(k);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!arready && k < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      k++;
    end while (!rvalid && k < 50);
    rready <= 1'b0;
    d = rdata;
    rsp = rresp;
    tmo(k);
  endtask
  // Let a snapshot refresh land
  task automatic settle();
    repeat (2 * SP + 5) @(posedge clk);
  endtask
  function automatic logic [31:0] wrap(input logic [31:0] v, input bit wide);
    return wide ? v : v & MASK16;
  endfunction
  initial begin
    {reset, alarm_n, gate, latch, open_det, awvalid, wvalid, bready, arvalid, rready} = 12'hC00;
    {awaddr, araddr, wdata, cyc, mismatches, cmp_count} = '0;
    void'($urandom(32'ha56dde43));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rdr(OFS_CTRL, rd); chk("ctrl", rd, CTRL_RESET);
    rdr(OFS_MICRO, rd); chk("micro", rd, 32'h0000_0000);
    rdr(8'h20, rd); chk("unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h20, 32'h0000_0001); chk("unmapped write", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    settle();
    rdr(OFS_STATUS, rd); chk("status", rd & 32'hFFFF_FFBF, 32'h0000_1080);
    $display("reset test done");
    n = 3 + $urandom % 8;
    m = 1 + $urandom % n;
    wr(OFS_CTRL, 32'h0000_000C); chk("write resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    rdr(OFS_CTRL, rd); chk("ctrl back", rd, 32'h0000_000C);
    qecnt_enc_model_i.pulse(n, 1'b0);
    qecnt_enc_model_i.pulse(m, 1'b1);
    settle();
    rdr(OFS_COUNT, rd); chk("pulse count", rd, wrap(n - m, 0));
    $display("pulse test done");
    n = 2 + $urandom % 20;
    m = $urandom % 40;
    wr(OFS_CTRL, 32'h0000_0008);
    wr(OFS_PRESET, 32'h0000_FFFE);
    wr(OFS_CMD, 32'h0000_0001);
    qecnt_enc_model_i.quad(n, 1'b1);
    qecnt_enc_model_i.quad(m, 1'b0);
    settle();
    ex = wrap(32'h0000_FFFE + n - m, 0);
    rdr(OFS_COUNT, rd); chk("quad count", rd, ex);
    wr(OFS_CTRL, 32'h0000_0048);
    gate <= 1'b1;
    qecnt_enc_model_i.quad(6, 1'b1);
    settle();
    rdr(OFS_COUNT, rd); chk("gated count", rd, ex);
    rdr(OFS_STATUS, rd); chk("gate flag", {31'h0, rd[8]}, 32'h1);
    gate <= 1'b0;
    $display("quad test done");
    wr(OFS_CTRL, 32'h0000_001B);
    wr(OFS_PRESET, 32'hFFFF_FFFF);
    wr(OFS_CMD, 32'h0000_0001);
    qecnt_enc_model_i.quad(2, 1'b1);
    qecnt_enc_model_i.zero();
    settle();
    rdr(OFS_COUNT, rd); chk("wide count", rd, wrap(32'h0000_0001, 1));
    rdr(OFS_CAPTURE, rd); chk("capture", rd, 32'h0000_0001);
    rdr(OFS_STATUS, rd); chk("capture flags", {30'h0, rd[1:0]}, 32'h3);
    rdr(OFS_EDGE_TS, rd); chk("stamp", {31'h0, rd != 0}, 32'h1);
    wr(OFS_CTRL, 32'h0000_039B);
    m = 1 + $urandom % 7;
    open_det <= m[2:0];
    settle();
    rdr(OFS_STATUS, rd); chk("open fault", {26'h0, rd[11:9], rd[5:3]}, {26'h0, m[2:0], 3'b111});
    open_det <= 3'b000;
    wr(OFS_CMD, 32'h0000_0004);
    settle();
    rdr(OFS_STATUS, rd); chk("valid cleared", {31'h0, rd[0]}, 32'h0);
    wr(OFS_CTRL, 32'h0000_002B);
    qecnt_enc_model_i.quad(3, 1'b1);
    repeat (4) @(posedge clk);
    latch <= 1'b1;
    settle();
    rdr(OFS_CAPTURE, rd); chk("latch capture", rd, 32'h0000_0004);
    latch <= 1'b0;
    ex = $urandom;
    wr(OFS_PRESET, ex);
    wr(OFS_CMD, 32'h0000_0002);
    settle();
    rdr(OFS_CAPTURE, rd); chk("capture preset", rd, ex);
    $display("enhanced test done");
    wr(OFS_STATE, {28'h0, STATE_OP});
    alarm_n <= 1'b0;
    settle();
    rdr(OFS_STATUS, rd); chk("op alarm", {26'h0, rd[15:12], rd[7], rd[2]}, 32'h21);
    chk("alarm led", {31'h0, led}, 32'h1);
    alarm_n <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0008);
    repeat (3) @(posedge clk);
    t = cyc;
    rdr(OFS_STATUS, ex);
    while (cyc < t + SP) @(posedge clk);
    rdr(OFS_STATUS, rd); chk("toggle", {31'h0, rd[6]}, {31'h0, ~ex[6]});
    chk("normal again", {31'h0, rd[1]}, 32'h0);
    $display("status test done");
    close_out();
  end
endmodule
